// ==== logic/ssm_baud_gen.sv ====
`timescale 1ns/100ps
module ssm_baud_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [7:0] divisor,
   output logic rise_pulse,
   output logic fall_pulse,
   output logic phase
);
   logic [7:0] count_reg;

   // ------------------------------------------------------------
   // down counter, reloads on every expiry
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= ssm_pkg::DIVISOR_RESET;
         phase <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end else if (!run) begin // [R11]
         // count held at zero so the first clock comes at once
         count_reg <= ssm_pkg::DIVISOR_RESET;
         phase <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end else if (count_reg == ssm_pkg::DIVISOR_RESET) begin // [R18]
         count_reg <= divisor;
         phase <= ~phase;
         rise_pulse <= ~phase;
         fall_pulse <= phase;
      end else begin
         count_reg <= count_reg - 8'h01;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end
   end
endmodule // ssm_baud_gen

// ==== logic/ssm_pkg.sv ====
package ssm_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] TX_CONTROL_STATUS_ADDR = 8'h00;
   localparam logic [7:0] RX_CONTROL_STATUS_ADDR = 8'h04;
   localparam logic [7:0] BAUD_DIVISOR_ADDR = 8'h08;
   localparam logic [7:0] TX_HOLDING_BUFFER_ADDR = 8'h0C;
   localparam logic [7:0] PERIPHERAL_FLAGS_1_ADDR = 8'h10;
   localparam logic [7:0] EVENT_STATUS_ADDR = 8'h14;
   localparam logic [7:0] PERIPHERAL_ENABLES_1_ADDR = 8'h18;
   localparam logic [7:0] IRQ_CONTROL_ADDR = 8'h1C;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   // tx_control_status
   localparam int CLOCK_SOURCE_MASTER_BIT = 7;
   localparam int NINE_BIT_SELECT_BIT = 6;
   localparam int TRANSMIT_ENABLE_BIT = 5;
   localparam int SYNC_SELECT_BIT = 4;
   localparam int SHIFT_REG_EMPTY_BIT = 1;
   localparam int NINTH_TX_BIT_BIT = 0;
   // rx_control_status
   localparam int SERIAL_PORT_ENABLE_BIT = 7;
   localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
   localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
   // peripheral_flags_1, event status and peripheral_enables_1
   localparam int TX_BUFFER_EMPTY_BIT = 4;
   localparam int WORD_SENT_BIT = 1;
   // irq_control
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;

   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int REG_W = 8;
   localparam int WORD_W = 9;
   localparam int CNT_W = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;

   typedef enum logic [1:0] {
      SSM_APB_IDLE,
      SSM_APB_WAIT,
      SSM_APB_DONE
   } ssm_apb_state_t;
endpackage

// ==== logic/ssm_sync_tx.sv ====
// Overview of operation
// R01: half duplex: receive and transmit never together
// R02: sync select and port enable claim pins
// R03: master bit makes device drive clock
// R04: reload shifter only after last bit
// R05: one-cycle transfer empties buffer, sets flag
// R06: empty flag ignores enable, cleared by write
// R07: read-only shift-empty bit, no interrupt
// R08: shift register not visible to software
// R09: enable alone sends nothing until loaded
// R10: bit out on rise, stable at fall
// R11: baud generator idle unless tx/rx enabled
// R12: write with shifter empty passes straight through
// R13: clearing enable aborts, resets, floats pins
// R14: receive enable aborts, floats data, holds logic
// R15: single receive done clears bit, resumes
// R16: ninth bit copied at moment of transfer
// R17: software follows fixed setup order
// R18: divisor counts down, toggles clock, reloads
// R19: clock idles low between words
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
module ssm_sync_tx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_word_done,
   output logic shift_clock_line_out,
   output logic shift_clock_line_oe,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   output logic irq
);
   logic [7:0] tx_control_status_reg;
   logic [7:0] rx_control_status_reg;
   logic [7:0] baud_divisor_reg;
   logic [7:0] tx_holding_buffer_reg;
   logic [7:0] event_status_reg;
   logic [7:0] event_status_next;
   logic [7:0] peripheral_enables_1_reg;
   logic [7:0] irq_control_reg;
   logic tx_buffer_empty_flag;
   ssm_pkg::ssm_apb_state_t apb_state_reg;
   logic wr_go;
   logic wr_holding;
   logic clock_source_master;
   logic nine_bit_select;
   logic transmit_enable;
   logic sync_select;
   logic ninth_tx_bit;
   logic serial_port_enable;
   logic single_receive_enable;
   logic continuous_receive_enable;
   logic receiving;
   logic brg_run;
   logic xfer;
   logic shift_busy;
   logic shift_reg_empty;
   logic word_sent;
   logic shift_data;
   logic shift_ck;
   logic rise_pulse;
   logic fall_pulse;
   logic brg_phase;
   logic [7:0] rd_mux;
   logic addr_ok;
   logic pins_claimed;
   logic wr_tx_ctrl;
   logic wr_rx_ctrl;
   logic wr_baud;
   logic wr_enables;
   logic wr_irq_ctrl;
   logic wr_events;
   logic irq_pending;

   // full decode: holes answer with an error and write nothing
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == ssm_pkg::TX_CONTROL_STATUS_ADDR) ||
         (a == ssm_pkg::RX_CONTROL_STATUS_ADDR) ||
         (a == ssm_pkg::BAUD_DIVISOR_ADDR) ||
         (a == ssm_pkg::TX_HOLDING_BUFFER_ADDR) ||
         (a == ssm_pkg::PERIPHERAL_FLAGS_1_ADDR) ||
         (a == ssm_pkg::EVENT_STATUS_ADDR) ||
         (a == ssm_pkg::PERIPHERAL_ENABLES_1_ADDR) ||
         (a == ssm_pkg::IRQ_CONTROL_ADDR);
   endfunction

   function automatic logic reg_hit(input logic go, input logic [7:0] a,
      input logic [7:0] target);
      reg_hit = go && (a == target);
   endfunction

   assign clock_source_master = tx_control_status_reg[ssm_pkg::CLOCK_SOURCE_MASTER_BIT];
   assign nine_bit_select = tx_control_status_reg[ssm_pkg::NINE_BIT_SELECT_BIT];
   assign transmit_enable = tx_control_status_reg[ssm_pkg::TRANSMIT_ENABLE_BIT];
   assign sync_select = tx_control_status_reg[ssm_pkg::SYNC_SELECT_BIT];
   assign ninth_tx_bit = tx_control_status_reg[ssm_pkg::NINTH_TX_BIT_BIT];
   assign serial_port_enable = rx_control_status_reg[ssm_pkg::SERIAL_PORT_ENABLE_BIT];
   assign single_receive_enable = rx_control_status_reg[ssm_pkg::SINGLE_RECEIVE_ENABLE_BIT];
   assign continuous_receive_enable =
      rx_control_status_reg[ssm_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
   assign receiving = single_receive_enable | continuous_receive_enable; // [R01]
   assign brg_run = transmit_enable | receiving; // [R11]
   // both pins belong to the port only in synchronous mode
   assign pins_claimed = serial_port_enable && sync_select; // [R02]
   assign shift_reg_empty = ~shift_busy; // [R07]

   // ------------------------------------------------------------
   // apb slave: one wait state, answer from flops
   // ------------------------------------------------------------
   assign addr_ok = addr_mapped(paddr);
   assign wr_go = psel && penable && pwrite && pready && addr_ok;
   assign wr_holding = reg_hit(wr_go, paddr, ssm_pkg::TX_HOLDING_BUFFER_ADDR);
   assign wr_tx_ctrl = reg_hit(wr_go, paddr, ssm_pkg::TX_CONTROL_STATUS_ADDR);
   assign wr_rx_ctrl = reg_hit(wr_go, paddr, ssm_pkg::RX_CONTROL_STATUS_ADDR);
   assign wr_baud = reg_hit(wr_go, paddr, ssm_pkg::BAUD_DIVISOR_ADDR);
   assign wr_enables = reg_hit(wr_go, paddr, ssm_pkg::PERIPHERAL_ENABLES_1_ADDR);
   assign wr_irq_ctrl = reg_hit(wr_go, paddr, ssm_pkg::IRQ_CONTROL_ADDR);
   assign wr_events = reg_hit(wr_go, paddr, ssm_pkg::EVENT_STATUS_ADDR);

   always_comb begin
      case (paddr)
         ssm_pkg::TX_CONTROL_STATUS_ADDR: begin
            rd_mux = tx_control_status_reg;
            rd_mux[ssm_pkg::SHIFT_REG_EMPTY_BIT] = shift_reg_empty; // [R07]
         end
         ssm_pkg::RX_CONTROL_STATUS_ADDR: rd_mux = rx_control_status_reg;
         ssm_pkg::BAUD_DIVISOR_ADDR: rd_mux = baud_divisor_reg;
         ssm_pkg::TX_HOLDING_BUFFER_ADDR: rd_mux = tx_holding_buffer_reg;
         ssm_pkg::PERIPHERAL_FLAGS_1_ADDR: begin
            rd_mux = 8'h00;
            rd_mux[ssm_pkg::TX_BUFFER_EMPTY_BIT] = tx_buffer_empty_flag;
         end
         ssm_pkg::EVENT_STATUS_ADDR: rd_mux = event_status_reg;
         ssm_pkg::PERIPHERAL_ENABLES_1_ADDR: rd_mux = peripheral_enables_1_reg;
         ssm_pkg::IRQ_CONTROL_ADDR: rd_mux = irq_control_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // answer comes from flops: pready trails the access by one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_state_reg <= ssm_pkg::SSM_APB_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         case (apb_state_reg)
            ssm_pkg::SSM_APB_IDLE: begin
               if (psel && penable) begin
                  apb_state_reg <= ssm_pkg::SSM_APB_WAIT;
                  pready <= 1'b1;
                  pslverr <= ~addr_ok;
                  prdata <= {24'h00_0000, rd_mux};
               end
            end
            ssm_pkg::SSM_APB_WAIT: begin
               apb_state_reg <= ssm_pkg::SSM_APB_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default: begin
               apb_state_reg <= ssm_pkg::SSM_APB_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_control_status_reg <= ssm_pkg::CTRL_RESET;
      end else if (wr_tx_ctrl) begin
         // shift-empty position is read-only
         tx_control_status_reg <= pwdata[7:0] &
            ~(8'h01 << ssm_pkg::SHIFT_REG_EMPTY_BIT); // [R02] [R03] [R16]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_control_status_reg <= ssm_pkg::CTRL_RESET;
      end else if (wr_rx_ctrl) begin
         rx_control_status_reg <= pwdata[7:0];
      end else if (rx_word_done && single_receive_enable) begin
         // single word received: hand the pin back to the transmitter
         rx_control_status_reg[ssm_pkg::SINGLE_RECEIVE_ENABLE_BIT] <= 1'b0; // [R15]
      end
   end

   // a new divisor takes effect at the next expiry, not mid-count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_divisor_reg <= ssm_pkg::DIVISOR_RESET;
      end else if (wr_baud) begin
         baud_divisor_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_enables_1_reg <= ssm_pkg::CTRL_RESET;
      end else if (wr_enables) begin
         peripheral_enables_1_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_control_reg <= ssm_pkg::CTRL_RESET;
      end else if (wr_irq_ctrl) begin
         irq_control_reg <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // holding buffer and its empty flag
   // ------------------------------------------------------------
   // transfer only with transmit enabled and pins not lent to the receiver
   assign xfer = ~tx_buffer_empty_flag && shift_reg_empty && transmit_enable &&
      ~receiving && ~wr_holding; // [R04] [R09] [R12]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_buffer_reg <= 8'h00;
      end else if (wr_holding) begin
         tx_holding_buffer_reg <= pwdata[7:0];
      end
   end

   // a buffer write beats a transfer in the same cycle; the transfer waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (wr_holding) begin
         tx_buffer_empty_flag <= 1'b0; // [R06]
      end else if (xfer) begin
         tx_buffer_empty_flag <= 1'b1; // [R05] [R06]
      end
   end

   // ------------------------------------------------------------
   // interrupt events: sticky, write one to clear, set wins
   // ------------------------------------------------------------
   always_comb begin
      event_status_next = event_status_reg;
      if (wr_events) begin
         event_status_next = event_status_reg & ~pwdata[7:0];
      end
      if (xfer) begin
         event_status_next[ssm_pkg::TX_BUFFER_EMPTY_BIT] = 1'b1; // [R05]
      end
      if (word_sent) begin
         event_status_next[ssm_pkg::WORD_SENT_BIT] = 1'b1;
      end
   end

   // status survives a masked interrupt; only a written one clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_status_reg <= 8'h00;
      end else begin
         event_status_reg <= event_status_next;
      end
   end

   // the two control bits mute the level without touching the status
   assign irq_pending = |(event_status_reg & peripheral_enables_1_reg) &&
      irq_control_reg[ssm_pkg::GLOBAL_IRQ_ENABLE_BIT] &&
      irq_control_reg[ssm_pkg::PERIPHERAL_IRQ_ENABLE_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_pending;
      end
   end

   // ------------------------------------------------------------
   // baud generator and shifter
   // ------------------------------------------------------------
   // generator runs only while some direction needs a clock
   ssm_baud_gen u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .run(brg_run),
      .divisor(baud_divisor_reg),
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse),
      .phase(brg_phase)
   );

   // ninth bit is read live at the load, so software sets it first
   ssm_tx_shifter u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .clear(~transmit_enable),
      .hold(receiving),
      .load(xfer),
      .load_word({ninth_tx_bit, tx_holding_buffer_reg}), // [R16]
      .nine(nine_bit_select),
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse),
      .busy(shift_busy),
      .done_pulse(word_sent),
      .data_bit(shift_data),
      .ck_level(shift_ck)
   );

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // receive clock runs free from the generator; transmit clock is gated per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_clock_line_out <= 1'b0;
         shift_clock_line_oe <= 1'b0;
         serial_data_line_out <= 1'b0;
         serial_data_line_oe <= 1'b0;
      end else begin
         shift_clock_line_oe <= pins_claimed && clock_source_master &&
            brg_run; // [R02] [R03] [R13] [R14]
         shift_clock_line_out <= receiving ? brg_phase : shift_ck; // [R19]
         serial_data_line_oe <= pins_claimed && transmit_enable &&
            ~receiving; // [R01] [R13] [R14] [R15]
         serial_data_line_out <= shift_data; // [R10]
      end
   end
endmodule // ssm_sync_tx

// ==== logic/ssm_tx_shifter.sv ====
`timescale 1ns/100ps
module ssm_tx_shifter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic hold,
   input wire logic load,
   input wire logic [8:0] load_word,
   input wire logic nine,
   input wire logic rise_pulse,
   input wire logic fall_pulse,
   output logic busy,
   output logic done_pulse,
   output logic data_bit,
   output logic ck_level
);
   // not mapped anywhere: only reachable through load
   logic [8:0] shift_reg; // [R08]
   logic [3:0] left_reg;

   // ------------------------------------------------------------
   // shifting, lsb first
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= 9'h000;
         left_reg <= 4'h0;
         busy <= 1'b0;
         done_pulse <= 1'b0;
         data_bit <= 1'b0;
         ck_level <= 1'b0;
      end else if (clear) begin // [R13]
         shift_reg <= 9'h000;
         left_reg <= 4'h0;
         busy <= 1'b0;
         done_pulse <= 1'b0;
         data_bit <= 1'b0;
         ck_level <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         if (load) begin
            shift_reg <= load_word;
            left_reg <= nine ? ssm_pkg::BITS_NINE : ssm_pkg::BITS_EIGHT;
            busy <= 1'b1;
         end else if (hold) begin
            // frozen, not reset, while the pin belongs to the receiver
            busy <= busy; // [R14]
         end else if (busy && rise_pulse && left_reg != 4'h0) begin // [R10]
            data_bit <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[8:1]};
            left_reg <= left_reg - 4'h1;
            ck_level <= 1'b1;
         end else if (busy && fall_pulse && ck_level) begin
            ck_level <= 1'b0; // [R19]
            if (left_reg == 4'h0) begin // [R04]
               busy <= 1'b0;
               done_pulse <= 1'b1;
            end
         end
      end
   end
endmodule // ssm_tx_shifter

// ==== sim/ssm_properties.sv ====
`timescale 1ns/100ps
module ssm_checker (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic rx_word_done,
   input logic shift_clock_line_out,
   input logic shift_clock_line_oe,
   input logic serial_data_line_out,
   input logic serial_data_line_oe,
   input logic irq
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access_first;
      psel && penable && !$past(penable);
   endsequence
   sequence s_ck_rise;
      shift_clock_line_oe && $rose(shift_clock_line_out);
   endsequence
   a_ready_latency: assert property (s_access_first |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_ready_has_request: assert property (pready |-> $past(psel && penable))
      else $error("pready without request");
   a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad refusal");
   a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_data_needs_clock: assert property (
      serial_data_line_oe |-> shift_clock_line_oe) else $error("data without clock");
   a_data_on_rise: assert property (
      serial_data_line_oe && $past(serial_data_line_oe) && $changed(serial_data_line_out)
      |-> $rose(shift_clock_line_out)) else $error("data moved off rise");
   a_stable_at_fall: assert property (
      serial_data_line_oe && $fell(shift_clock_line_out) |-> $stable(serial_data_line_out))
      else $error("data moved at fall");
   a_clock_phase_bound: assert property (
      s_ck_rise |-> ##[1:256] (!shift_clock_line_out || !shift_clock_line_oe))
      else $error("clock high too long");
endmodule // ssm_checker

bind ssm_sync_tx ssm_checker ssm_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_word_done(rx_word_done),
   .shift_clock_line_out(shift_clock_line_out), .shift_clock_line_oe(shift_clock_line_oe),
   .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
   .irq(irq));

// ==== sim/ssm_slave_model.sv ====
`timescale 1ns/100ps
module ssm_slave_model (
   input wire logic pclk,
   input wire logic ck,
   input wire logic dt,
   input wire logic dt_driven,
   input wire logic nine
);
   logic ck_q;
   logic [8:0] sh;
   logic [8:0] words [0:15];
   int nbits;
   int nw;
   int hi_cnt;
   int hi_len;
   initial begin
      ck_q = 1'b0;
      sh = 9'h000;
      nbits = 0;
      nw = 0;
      hi_cnt = 0;
      hi_len = 0;
   end
   // sampled on pclk so a released clock line never fakes an edge
   always @(posedge pclk) begin
      if (!dt_driven) begin
         nbits = 0;
      end else if (ck_q && !ck) begin
         hi_len = hi_cnt;
         sh[nbits] = dt;
         nbits = nbits + 1;
         if (nbits == (nine ? 9 : 8)) begin
            words[nw[3:0]] = nine ? sh : {1'b0, sh[7:0]};
            nw = nw + 1;
            nbits = 0;
         end
      end
      hi_cnt = ck ? hi_cnt + 1 : 0;
      ck_q = ck;
   end
endmodule // ssm_slave_model

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   localparam logic [7:0] A_TX = ssm_pkg::TX_CONTROL_STATUS_ADDR;
   localparam logic [7:0] A_RX = ssm_pkg::RX_CONTROL_STATUS_ADDR;
   localparam logic [7:0] A_BUF = ssm_pkg::TX_HOLDING_BUFFER_ADDR;
   localparam logic [7:0] A_FL = ssm_pkg::PERIPHERAL_FLAGS_1_ADDR;
   localparam logic [7:0] A_EV = ssm_pkg::EVENT_STATUS_ADDR;
   localparam logic [7:0] A_MK = ssm_pkg::PERIPHERAL_ENABLES_1_ADDR;
   localparam logic [7:0] A_IC = ssm_pkg::IRQ_CONTROL_ADDR;
   logic pclk, presetn, psel, penable, pwrite, rx_word_done, pready, pslverr, irq, er;
   logic ck_out, ck_oe, dt_out, dt_oe, ck_w, dt_w, nine;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int err_count, num_checks;
   // released pins: clock pulled low, data pulled high
   assign ck_w = ck_oe ? ck_out : 1'b0;
   assign dt_w = dt_oe ? dt_out : 1'b1;
   ssm_sync_tx ssm_sync_tx_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_word_done(rx_word_done),
      .shift_clock_line_out(ck_out), .shift_clock_line_oe(ck_oe),
      .serial_data_line_out(dt_out), .serial_data_line_oe(dt_oe), .irq(irq));
   ssm_slave_model ssm_slave_model_inst (.pclk(pclk), .ck(ck_w), .dt(dt_w),
      .dt_driven(dt_oe), .nine(nine));
   // ------------------------------------------------------------
   // bus and helpers
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task final_report;
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) `CHK("pready", 1'b1, pready)
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK("read", exp, rd)
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task wait_words(input int n);
      int i;
      i = 0;
      while (ssm_slave_model_inst.nw < n && i < 600) begin
         @(posedge pclk);
         i++;
      end
      `CHK("words", 1'b1, ssm_slave_model_inst.nw >= n)
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset_state;
      rchk(A_TX, 32'h02);
      rchk(A_FL, 32'h10);
      rchk(A_EV, 32'h00);
      apb(1'b0, 8'h20, 32'h0);
      `CHK("slverr", 1'b1, er)
      apb(1'b1, A_TX, 32'h00);
      rchk(A_TX, 32'h02);
      apb(1'b1, A_FL, 32'h00);
      rchk(A_FL, 32'h10);
   endtask
   task t_enable_idle;
      apb(1'b1, ssm_pkg::BAUD_DIVISOR_ADDR, 32'h02);
      apb(1'b1, A_RX, 32'h80);
      apb(1'b1, A_TX, 32'hB0);
      cyc(30);
      rchk(A_FL, 32'h10);
      rchk(A_EV, 32'h00);
      rchk(A_TX, 32'hB2);
   endtask
   task t_back_to_back;
      apb(1'b1, A_BUF, 32'hA5);
      rchk(A_FL, 32'h10);
      apb(1'b1, A_BUF, 32'h3C);
      rchk(A_FL, 32'h00);
      rchk(A_TX, 32'hB0);
      wait_words(2);
      `CHK("word0", 9'h0A5, ssm_slave_model_inst.words[0])
      `CHK("word1", 9'h03C, ssm_slave_model_inst.words[1])
      `CHK("high len", 3, ssm_slave_model_inst.hi_len)
      cyc(20);
      `CHK("ck idle", 1'b0, ck_out)
      rchk(A_TX, 32'hB2);
      rchk(A_EV, 32'h12);
      apb(1'b1, A_IC, 32'hC0);
      apb(1'b1, A_MK, 32'h10);
      cyc(2);
      `CHK("irq on", 1'b1, irq)
      apb(1'b1, A_MK, 32'h00);
      cyc(2);
      `CHK("irq masked", 1'b0, irq)
      rchk(A_FL, 32'h10);
      apb(1'b1, A_EV, 32'h12);
      rchk(A_EV, 32'h00);
   endtask
   task t_ninth;
      nine = 1'b1;
      apb(1'b1, A_TX, 32'hF1);
      apb(1'b1, A_BUF, 32'h55);
      apb(1'b1, A_TX, 32'hF0);
      apb(1'b1, A_BUF, 32'hAA);
      wait_words(4);
      `CHK("ninth set", 9'h155, ssm_slave_model_inst.words[2])
      `CHK("ninth clear", 9'h0AA, ssm_slave_model_inst.words[3])
      cyc(20);
      apb(1'b1, A_TX, 32'hB0);
      nine = 1'b0;
   endtask
   task t_abort;
      apb(1'b1, A_BUF, 32'hFF);
      cyc(15);
      apb(1'b1, A_TX, 32'h90);
      cyc(2);
      `CHK("ck oe", 1'b0, ck_oe)
      `CHK("dt oe", 1'b0, dt_oe)
      rchk(A_TX, 32'h92);
      `CHK("no word", 4, ssm_slave_model_inst.nw)
   endtask
   task t_rx_abort;
      apb(1'b1, A_TX, 32'hB0);
      apb(1'b1, A_BUF, 32'h0F);
      cyc(15);
      apb(1'b1, A_RX, 32'hA0);
      cyc(2);
      `CHK("dt float", 1'b0, dt_oe)
      `CHK("ck kept", 1'b1, ck_oe)
      rchk(A_TX, 32'hB0);
      rx_word_done <= 1'b1;
      @(posedge pclk);
      rx_word_done <= 1'b0;
      cyc(2);
      `CHK("dt back", 1'b1, dt_oe)
      rchk(A_RX, 32'h80);
      apb(1'b1, A_RX, 32'h90);
      cyc(2);
      `CHK("dt float cont", 1'b0, dt_oe)
      `CHK("ck kept cont", 1'b1, ck_oe)
      rchk(A_TX, 32'hB0);
      apb(1'b1, A_RX, 32'h80);
      apb(1'b1, A_TX, 32'h90);
   endtask
   initial begin
      {psel, penable, pwrite, rx_word_done, nine, presetn} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      num_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_state;
      t_enable_idle;
      t_back_to_back;
      t_ninth;
      t_abort;
      t_rx_abort;
      final_report;
   end
   initial begin
      #(100 * 20000);
      err_count++;
      final_report;
   end
endmodule // testbench
